// [hci_uart_map.svh]
// Constants for the host-interface UART transport: clock, baud limits,
// flow-control characters, SLIP characters and FIFO watermarks.
// Assumes a 200 MHz core clock and integer cycles-per-bit divisors.
`ifndef HCI_UART_MAP_SVH
`define HCI_UART_MAP_SVH

// Core clock in Hz
`define CLK_HZ 200000000
// Baud figures in bits per second
`define BAUD_DEF 115200
`define BAUD_MIN 9600
`define BAUD_MAX 4000000
// Cycles per bit derived from the rates
`define DIV_DEF (`CLK_HZ / `BAUD_DEF)
`define DIV_SLOW (`CLK_HZ / `BAUD_MIN)
`define DIV_FAST (`CLK_HZ / `BAUD_MAX)
// FIFO size in bytes and receive-ready watermarks
`define FIFO_DEPTH 1040
`define RTS_HI_MARK 1024
`define RTS_LO_MARK 512
// In-band software flow-control characters
`define CH_XON 8'h11
`define CH_XOFF 8'h13
// SLIP characters
`define SLIP_END 8'hC0
`define SLIP_ESC 8'hDB
`define SLIP_ESC_END 8'hDC
`define SLIP_ESC_ESC 8'hDD

`endif

// [hci_uart_pkg.sv]
// Types shared by the host-interface UART transport.
// Assumes hci_uart_map.svh supplies the numeric constants.
package hci_uart_pkg;

   // Framing selection
   typedef enum logic [1:0] {MODE_H4, MODE_H4X, MODE_H5} hci_mode_t;

   // One FIFO entry: a byte, or a SLIP frame delimiter when delim is set
   typedef struct packed {
      logic delim;
      logic [7:0] data;
   } fifo_word_t;

   // Serial state machines
   typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} ser_state_t;

endpackage

// [hci_uart_transport.sv]
// Four-wire host-interface UART with large FIFOs, autobaud, XON/XOFF,
// SLIP support and wake on line activity.
// Assumes all inputs are synchronous to clk_i; the FIFO side is driven by
// a DMA engine or the CPU through the valid/ready ports.
`timescale 1ns/100ps
`include "hci_uart_map.svh"

// Byte FIFO kept in a local array
module hci_fifo #(
   parameter int W = 9,
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int AW = 11
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [AW:0] count_o
);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   logic push, pop;

   // Handshakes
   assign in_ready_o = cnt_q < (AW+1)'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o = mem[rd_q];
   assign count_o = cnt_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // Storage
   always_ff @(posedge clk_i)
   begin
      if (ce_i && push)
         mem[wr_q] <= in_data_i;
   end

   // Pointers and fill level
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else if (ce_i)
      begin
         if (push)
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module hci_uart_transport #(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int AW = 11
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire hci_uart_pkg::hci_mode_t mode_i,
   input wire logic sw_flow_en_i,
   input wire logic slip_en_i,
   input wire logic baud_wr_i,
   input wire logic [15:0] baud_div_i,
   input wire logic autobaud_en_i,
   output logic [15:0] baud_div_o,
   output logic autobaud_done_o,
   input wire logic rx_i,
   output logic tx_o,
   input wire logic cts_n_i,
   output logic rts_n_o,
   input wire logic sleep_i,
   output logic wake_o,
   input wire logic tx_valid_i,
   input wire hci_uart_pkg::fifo_word_t tx_data_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output hci_uart_pkg::fifo_word_t rx_data_o,
   input wire logic rx_ready_i,
   output logic [AW:0] rx_level_o,
   output logic tx_paused_o
);
   import hci_uart_pkg::*;

   logic [15:0] div_q, ab_cnt_q;
   logic ab_done_q, ab_meas_q, rx_q, cts_q, wake_q, hist_q;
   ser_state_t rs_q, ts_q;
   logic [15:0] rcnt_q, tcnt_q;
   logic [2:0] rbit_q, tbit_q;
   logic [7:0] rsh_q, tsh_q;
   logic resc_q, paused_q, rts_n_q, tx_q, pend_q;
   logic [7:0] pend_byte_q;
   logic rx_byte, rx_push;
   fifo_word_t rx_word, txf_word;
   logic rxf_ready, txf_valid, txf_pop, tx_allow;
   logic [AW:0] rx_cnt;

   // Clamp a divisor into the supported baud range
   function automatic logic [15:0] clamp_div(input logic [15:0] d);
      if (d < 16'(`DIV_FAST))
         return 16'(`DIV_FAST);
      else if (d > 16'(`DIV_SLOW))
         return 16'(`DIV_SLOW);
      else
         return d;
   endfunction

   // Line history for edge and activity detection
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_q <= 1'b1;
         cts_q <= 1'b1;
         hist_q <= 1'b0;
      end
      else if (ce_i)
      begin
         rx_q <= rx_i;
         cts_q <= cts_n_i;
         hist_q <= 1'b1; // History valid after first sample
      end
   end

   // Baud divisor: reset default, host rewrite, autobaud result
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_q <= 16'(`DIV_DEF);
         ab_cnt_q <= '0;
         ab_meas_q <= 1'b0;
         ab_done_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (baud_wr_i)
            div_q <= clamp_div(baud_div_i);
         else if (autobaud_en_i && !ab_done_q)
         begin
            // Width of the first low pulse is one bit time
            if (ab_meas_q)
            begin
               if (rx_i)
               begin
                  div_q <= clamp_div(ab_cnt_q);
                  ab_done_q <= 1'b1;
                  ab_meas_q <= 1'b0;
               end
               else if (ab_cnt_q != 16'hFFFF)
                  ab_cnt_q <= ab_cnt_q + 16'h0001;
            end
            else if (rx_q && !rx_i)
            begin
               ab_meas_q <= 1'b1;
               ab_cnt_q <= 16'h0001;
            end
         end
         if (!autobaud_en_i)
            ab_done_q <= 1'b0;
      end
   end

   // Receiver: start, eight data bits LSB first, stop; mid-bit sampling
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rs_q <= S_IDLE;
         rcnt_q <= '0;
         rbit_q <= '0;
         rsh_q <= '0;
      end
      else if (ce_i)
      begin
         case (rs_q)
            S_IDLE:
               if (rx_q && !rx_i && !(autobaud_en_i && !ab_done_q))
               begin
                  rs_q <= S_START;
                  rcnt_q <= div_q >> 1;
               end
            S_START:
               if (rcnt_q == '0)
               begin
                  rs_q <= rx_i ? S_IDLE : S_DATA;
                  rcnt_q <= div_q - 16'h0001;
                  rbit_q <= '0;
               end
               else
                  rcnt_q <= rcnt_q - 16'h0001;
            S_DATA:
               if (rcnt_q == '0)
               begin
                  rsh_q <= {rx_i, rsh_q[7:1]};
                  rbit_q <= rbit_q + 3'h1;
                  rcnt_q <= div_q - 16'h0001;
                  if (rbit_q == 3'h7)
                     rs_q <= S_STOP;
               end
               else
                  rcnt_q <= rcnt_q - 16'h0001;
            S_STOP:
               if (rcnt_q == '0)
                  rs_q <= S_IDLE;
               else
                  rcnt_q <= rcnt_q - 16'h0001;
            default:
               rs_q <= S_IDLE;
         endcase
      end
   end

   // Byte complete at stop-bit midpoint with a high stop bit
   assign rx_byte = (rs_q == S_STOP) && (rcnt_q == '0) && rx_i;

   // Received byte handling: flow characters, SLIP decode, FIFO push
   always_comb
   begin
      rx_push = 1'b0;
      rx_word = '{delim: 1'b0, data: rsh_q};
      if (rx_byte)
      begin
         if (sw_flow_en_i && (rsh_q == `CH_XON || rsh_q == `CH_XOFF))
            rx_push = 1'b0;
         else if (slip_en_i && !resc_q && rsh_q == `SLIP_END)
         begin
            rx_push = 1'b1;
            rx_word.delim = 1'b1;
         end
         else if (slip_en_i && !resc_q && rsh_q == `SLIP_ESC)
            rx_push = 1'b0;
         else
         begin
            rx_push = 1'b1;
            if (slip_en_i && resc_q && rsh_q == `SLIP_ESC_END)
               rx_word.data = `SLIP_END;
            else if (slip_en_i && resc_q && rsh_q == `SLIP_ESC_ESC)
               rx_word.data = `SLIP_ESC;
         end
      end
   end

   // SLIP escape memory and XON/XOFF pause state
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         resc_q <= 1'b0;
         paused_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (rx_byte && sw_flow_en_i && rsh_q == `CH_XOFF)
            paused_q <= 1'b1;
         else if ((rx_byte && sw_flow_en_i && rsh_q == `CH_XON) || !sw_flow_en_i)
            paused_q <= 1'b0;
         if (rx_byte && !(sw_flow_en_i && (rsh_q == `CH_XON || rsh_q == `CH_XOFF)))
            resc_q <= slip_en_i && !resc_q && rsh_q == `SLIP_ESC;
      end
   end

   // Receive FIFO; a byte arriving when full is dropped
   hci_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) rx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(rx_push),
      .in_data_i(rx_word),
      .in_ready_o(rxf_ready),
      .out_valid_o(rx_valid_o),
      .out_data_o(rx_data_o),
      .out_ready_i(rx_ready_i),
      .count_o(rx_cnt)
   );
   assign rx_level_o = rx_cnt;

   // Receive-ready line with hysteresis; held low in three-wire mode
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         rts_n_q <= 1'b1;
      else if (ce_i)
      begin
         if (mode_i == MODE_H5)
            rts_n_q <= 1'b0;
         else if (rx_cnt >= (AW+1)'(`RTS_HI_MARK) || !rxf_ready)
            rts_n_q <= 1'b1;
         else if (rx_cnt <= (AW+1)'(`RTS_LO_MARK))
            rts_n_q <= 1'b0;
      end
   end

   // Transmit FIFO
   hci_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) tx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(tx_valid_i),
      .in_data_i(tx_data_i),
      .in_ready_o(tx_ready_o),
      .out_valid_o(txf_valid),
      .out_data_o(txf_word),
      .out_ready_i(txf_pop),
      .count_o()
   );

   // A new character may start only when idle, not paused and permitted
   assign tx_allow = (ts_q == S_IDLE) && !paused_q &&
                     (mode_i == MODE_H5 || !cts_n_i);
   assign txf_pop = tx_allow && !pend_q && txf_valid;

   // Transmitter with SLIP encoding of delimiters and escapes
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ts_q <= S_IDLE;
         tx_q <= 1'b1;
         tcnt_q <= '0;
         tbit_q <= '0;
         tsh_q <= '0;
         pend_q <= 1'b0;
         pend_byte_q <= '0;
      end
      else if (ce_i)
      begin
         case (ts_q)
            S_IDLE:
            begin
               tx_q <= 1'b1;
               tcnt_q <= div_q - 16'h0001;
               if (tx_allow && pend_q)
               begin
                  ts_q <= S_START;
                  tsh_q <= pend_byte_q;
                  pend_q <= 1'b0;
               end
               else if (txf_pop)
               begin
                  ts_q <= S_START;
                  tsh_q <= txf_word.data;
                  if (slip_en_i && txf_word.delim)
                     tsh_q <= `SLIP_END;
                  else if (slip_en_i && (txf_word.data == `SLIP_END ||
                                         txf_word.data == `SLIP_ESC))
                  begin
                     tsh_q <= `SLIP_ESC;
                     pend_q <= 1'b1;
                     pend_byte_q <= (txf_word.data == `SLIP_END) ?
                                    `SLIP_ESC_END : `SLIP_ESC_ESC;
                  end
               end
            end
            S_START:
            begin
               tx_q <= 1'b0;
               if (tcnt_q == '0)
               begin
                  ts_q <= S_DATA;
                  tcnt_q <= div_q - 16'h0001;
                  tbit_q <= '0;
               end
               else
                  tcnt_q <= tcnt_q - 16'h0001;
            end
            S_DATA:
            begin
               tx_q <= tsh_q[tbit_q];
               if (tcnt_q == '0)
               begin
                  tcnt_q <= div_q - 16'h0001;
                  tbit_q <= tbit_q + 3'h1;
                  if (tbit_q == 3'h7)
                     ts_q <= S_STOP;
               end
               else
                  tcnt_q <= tcnt_q - 16'h0001;
            end
            S_STOP:
            begin
               tx_q <= 1'b1;
               if (tcnt_q == '0)
                  ts_q <= S_IDLE;
               else
                  tcnt_q <= tcnt_q - 16'h0001;
            end
            default:
               ts_q <= S_IDLE;
         endcase
      end
   end

   // Wake request on line activity while asleep
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         wake_q <= 1'b0;
      else if (ce_i)
      begin
         if (!sleep_i)
            wake_q <= 1'b0;
         else if (hist_q && ((rx_i != rx_q) || (cts_n_i != cts_q)))
            wake_q <= 1'b1;
      end
   end

   // Outputs
   assign tx_o = tx_q;
   assign rts_n_o = rts_n_q;
   assign wake_o = wake_q;
   assign baud_div_o = div_q;
   assign autobaud_done_o = ab_done_q;
   assign tx_paused_o = paused_q;
endmodule

// [hci_uart_transport_properties.sv]
// Checker for the UART transport, bound to its top module.
// Assumes one clock domain and an async active-high reset.
`timescale 1ns/100ps
module hci_uart_transport_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire hci_uart_pkg::hci_mode_t mode_i,
   input wire logic baud_wr_i,
   input wire logic [15:0] baud_div_i,
   input wire logic [15:0] baud_div_o,
   input wire logic rx_i,
   input wire logic tx_o,
   input wire logic cts_n_i,
   input wire logic rts_n_o,
   input wire logic sleep_i,
   input wire logic wake_o,
   input wire logic tx_paused_o
);
   import hci_uart_pkg::*;
   logic [19:0] cnt_q;

   // Counts one character down from its start bit
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         cnt_q <= 20'h00000;
      else if (cnt_q != 20'h00000)
         cnt_q <= cnt_q - 20'h00001;
      else if ($fell(tx_o))
         cnt_q <= 20'(baud_div_o) * 20'h0000A - 20'h00001;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Start of a sent character, and middle of its stop bit
   sequence s_start;
      cnt_q == 20'h00000 && $fell(tx_o);
   endsequence
   sequence s_stop_mid;
      cnt_q == 20'(baud_div_o >> 1);
   endsequence

   property p_div_reset;
      $fell(rst_i) |-> baud_div_o == 16'h06C8;
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("bad reset divisor");
   property p_baud_load;
      baud_wr_i && ce_i && baud_div_i >= 16'h0032 && baud_div_i <= 16'h5161
         |=> baud_div_o == $past(baud_div_i);
   endproperty
   a_baud_load: assert property (p_baud_load) else $error("divisor not loaded");
   property p_clamp;
      baud_wr_i && ce_i && (baud_div_i < 16'h0032 || baud_div_i > 16'h5161)
         |=> baud_div_o == ($past(baud_div_i) < 16'h0032 ? 16'h0032 : 16'h5161);
   endproperty
   a_clamp: assert property (p_clamp) else $error("divisor not clamped");
   property p_h5_rts;
      !$past(rst_i) && $past(mode_i) == MODE_H5 |-> !rts_n_o;
   endproperty
   a_h5_rts: assert property (p_h5_rts) else $error("ready line used in H5");
   property p_tx_gate;
      s_start |-> ($past(mode_i, 2) == MODE_H5 || !$past(cts_n_i, 2))
         && !$past(tx_paused_o, 2);
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("start without permit");
   property p_tx_frame;
      s_start |-> !tx_o [*8];
   endproperty
   a_tx_frame: assert property (p_tx_frame) else $error("short start bit");
   property p_tx_stop;
      s_stop_mid |-> tx_o;
   endproperty
   a_tx_stop: assert property (p_tx_stop) else $error("stop bit low");
   property p_wake;
      !$past(rst_i) && sleep_i && $past(sleep_i)
         && (rx_i != $past(rx_i) || cts_n_i != $past(cts_n_i))
         |-> ##[1:2] wake_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on activity");
endmodule

bind hci_uart_transport hci_uart_transport_properties u_props (.*);

// [hci_host_model.sv]
// Behavioural host UART facing the transport across its serial lines.
// Assumes 8N1 characters and bit times counted in core clock cycles.
`timescale 1ns/100ps
module hci_host_model (
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic rts_n_i,
   output logic line_o,
   output logic cts_n_o
);
   int div = 50;
   logic [7:0] q[$];
   logic [7:0] rx_b;

   // Idle line high, device permitted to send
   initial
   begin
      line_o = 1'b1;
      cts_n_o = 1'b0;
   end

   // Permit line; high holds the device's next character
   task permit(input logic v);
      cts_n_o = v;
   endtask

   // One character at bt cycles per bit, once the device is ready
   task send(input logic [7:0] b, input int bt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (rts_n_i !== 1'b0)
         @(posedge clk_i);
      @(posedge clk_i);
      #1;
      for (int i = 0; i < 10; i++)
      begin
         line_o = f[i];
         repeat (bt) @(posedge clk_i);
         #1;
      end
   endtask

   // Receiver sampling mid-bit; bad stop bit drops the character
   always
   begin
      @(negedge line_i);
      repeat (div / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (div) @(posedge clk_i);
         rx_b[i] = line_i;
      end
      repeat (div) @(posedge clk_i);
      if (line_i === 1'b1)
         q.push_back(rx_b);
   end
endmodule

// [hci_uart_transport_tb.sv]
// Self-checking bench for the host-interface UART transport.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/100ps
module hci_uart_transport_tb;
   import hci_uart_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i, ce_i, sw_flow_en_i, slip_en_i, baud_wr_i, autobaud_en_i;
   logic sleep_i, tx_valid_i, rx_ready_i, rx_line, cts_n;
   logic autobaud_done_o, tx_o, rts_n_o, wake_o, tx_ready_o, rx_valid_o, tx_paused_o;
   logic [15:0] baud_div_i, baud_div_o;
   logic [11:0] rx_level_o;
   hci_mode_t mode_i;
   fifo_word_t tx_data_i, rx_data_o;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;

   hci_uart_transport uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mode_i(mode_i),
      .sw_flow_en_i(sw_flow_en_i), .slip_en_i(slip_en_i), .baud_wr_i(baud_wr_i),
      .baud_div_i(baud_div_i), .autobaud_en_i(autobaud_en_i), .baud_div_o(baud_div_o),
      .autobaud_done_o(autobaud_done_o), .rx_i(rx_line), .tx_o(tx_o), .cts_n_i(cts_n),
      .rts_n_o(rts_n_o), .sleep_i(sleep_i), .wake_o(wake_o), .tx_valid_i(tx_valid_i),
      .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o),
      .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i), .rx_level_o(rx_level_o),
      .tx_paused_o(tx_paused_o));
   hci_host_model host (.clk_i(clk_i), .line_i(tx_o), .rts_n_i(rts_n_o), .line_o(rx_line),
      .cts_n_o(cts_n));

   // 200 MHz clock
   initial
      forever #2.5 clk_i = ~clk_i;

   // Cycle ceiling against a hang
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_errors++;
         final_report();
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task final_report;
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task setb(input logic [15:0] v);
      baud_div_i = v;
      baud_wr_i = 1'b1;
      @(posedge clk_i);
      #1 baud_wr_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask

   task push(input logic d, input logic [7:0] b);
      tx_valid_i = 1'b1;
      tx_data_i = {d, b};
      while (tx_ready_o !== 1'b1)
      begin
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      #1 tx_valid_i = 1'b0;
   endtask

   // Next character seen by the host
   task hget(input logic [7:0] b);
      int n;
      n = 0;
      while (host.q.size() == 0 && n < 3000)
      begin
         @(posedge clk_i);
         n++;
      end
      #1;
      chk(host.q.size() > 0 ? {8'h00, host.q.pop_front()} : 16'hXXXX, {8'h00, b});
   endtask

   // Head of the receive FIFO, then pop it
   task rget(input logic d, input logic [7:0] b);
      int n;
      n = 0;
      while (rx_valid_o !== 1'b1 && n < 3000)
      begin
         @(posedge clk_i);
         #1 n++;
      end
      chk({6'h00, rx_valid_o, rx_data_o}, {6'h00, 1'b1, d, b});
      rx_ready_i = 1'b1;
      @(posedge clk_i);
      #1 rx_ready_i = 1'b0;
   endtask

   // Main sequence
   initial
   begin
      int n;
      rst_i = 1'b1;
      ce_i = 1'b1;
      mode_i = MODE_H4;
      sw_flow_en_i = 1'b0;
      slip_en_i = 1'b0;
      baud_wr_i = 1'b0;
      baud_div_i = 16'h0000;
      autobaud_en_i = 1'b0;
      sleep_i = 1'b0;
      tx_valid_i = 1'b0;
      tx_data_i = 9'h000;
      rx_ready_i = 1'b0;
      repeat (10) @(posedge clk_i);
      #1 rst_i = 1'b0;
      chk(baud_div_o, 16'h06C8);
      setb(16'h0010);
      chk(baud_div_o, 16'h0032);
      setb(16'hFFFF);
      chk(baud_div_o, 16'h5161);
      setb(16'h0032);
      chk(baud_div_o, 16'h0032);
      // Clock enable low freezes the divisor
      ce_i = 1'b0;
      setb(16'h0040);
      chk(baud_div_o, 16'h0032);
      ce_i = 1'b1;
      chk(16'(rts_n_o), 16'h0000);
      // Each framing mode; the three-wire one ignores the permit line
      for (int m = 0; m < 3; m++)
      begin
         mode_i = hci_mode_t'(m);
         host.permit(m == 2);
         push(1'b0, 8'h5A + 8'(m));
         hget(8'h5A + 8'(m));
      end
      // Permit high holds the next character until it drops
      mode_i = MODE_H4;
      push(1'b0, 8'h3C);
      repeat (1500) @(posedge clk_i);
      #1 chk(16'(host.q.size()), 16'h0000);
      host.permit(1'b0);
      n = 0;
      while (tx_o === 1'b1 && n < 100)
      begin
         @(posedge clk_i);
         #1 n++;
      end
      chk(16'(n <= 75), 16'h0001);
      hget(8'h3C);
      // Receive at bit times 2% off the device's
      host.send(8'hA5, 51);
      chk(16'(rx_level_o), 16'h0001);
      rget(1'b0, 8'hA5);
      host.send(8'h5A, 49);
      rget(1'b0, 8'h5A);
      // Pause on the off character, resume on the on character
      sw_flow_en_i = 1'b1;
      host.send(8'h13, 50);
      repeat (5) @(posedge clk_i);
      #1 chk(16'(tx_paused_o), 16'h0001);
      push(1'b0, 8'h69);
      repeat (1200) @(posedge clk_i);
      #1 chk(16'(host.q.size()), 16'h0000);
      host.send(8'h11, 50);
      hget(8'h69);
      chk(16'(rx_valid_o), 16'h0000);
      sw_flow_en_i = 1'b0;
      // Frame delimiter and escapes both ways
      slip_en_i = 1'b1;
      push(1'b1, 8'h00);
      hget(8'hC0);
      push(1'b0, 8'hC0);
      hget(8'hDB);
      hget(8'hDC);
      host.send(8'hDB, 50);
      host.send(8'hDD, 50);
      rget(1'b0, 8'hDB);
      host.send(8'hC0, 50);
      rget(1'b1, 8'hC0);
      slip_en_i = 1'b0;
      // Permit activity wakes a sleeping chip
      sleep_i = 1'b1;
      @(posedge clk_i);
      #1 host.permit(1'b1);
      repeat (3) @(posedge clk_i);
      #1 chk(16'(wake_o), 16'h0001);
      sleep_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk(16'(wake_o), 16'h0000);
      host.permit(1'b0);
      // Rate measured from a start bit 60 cycles wide
      autobaud_en_i = 1'b1;
      host.send(8'h01, 60);
      chk(16'(autobaud_done_o), 16'h0001);
      chk(16'(baud_div_o >= 16'h003B && baud_div_o <= 16'h003D), 16'h0001);
      autobaud_en_i = 1'b0;
      host.div = baud_div_o;
      push(1'b0, 8'h96);
      hget(8'h96);
      final_report();
   end
endmodule
